// *** acq_regs.vh ***
// register map, field positions, reset values and timing constants
`ifndef ACQ_REGS_VH
`define ACQ_REGS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CONFIG 8'h00
`define REG_TPD 8'h04
`define REG_STATUS 8'h08
`define REG_AUTOCFG 8'h0C
// ----------------------------------------
// config fields and reset values
// ----------------------------------------
`define CFG_SEGS_LSB 0
`define CFG_SEQTYPE_BIT 8
`define CFG_ILV_LSB 16
`define CFG_RESET 32'h0010_000A
`define TPD_RESET 32'h0000_03E8
// ----------------------------------------
// modes, one-hot
// ----------------------------------------
`define MODE_SINGLE 4'h1
`define MODE_NORMAL 4'h2
`define MODE_AUTO 4'h4
`define MODE_SEG 4'h8
// ----------------------------------------
// timing: times in their own units
// ----------------------------------------
`define CLK_KHZ 50000
`define AUTO_TMO_MS 100
`define AUTO_TMO_ILV_MS 200
`define TB_DEFAULT_NS 32'h0000_2710
`define SEG_SPAN_DIVS 10
// ----------------------------------------
// bus responses
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** acq_ctrl.v ***
// trigger mode and acquisition sequencing controller with axi4-lite registers
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`include "acq_regs.vh"
module acq_ctrl #(
    parameter NCH = 4,
    parameter [31:0] MEM_DEPTH = 32'h0001_0000,
    parameter [23:0] AUTO_TMO_CYC = `AUTO_TMO_MS * `CLK_KHZ,
    parameter [23:0] AUTO_TMO_ILV_CYC = `AUTO_TMO_ILV_MS * `CLK_KHZ
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // axi4-lite slave
    input wire [7:0] awaddr,
    input wire awvalid,
    output wire awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [7:0] araddr,
    input wire arvalid,
    output wire arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // front panel keys, one-cycle pulses
    input wire key_upper,
    input wire key_lower,
    input wire key_autocfg,
    // mode indicators
    output reg single_mode_indicator,
    output reg normal_mode_indicator,
    output reg auto_mode_indicator,
    output reg segmented_mode_indicator,
    // plug-in trigger detectors
    input wire [NCH-1:0] trig_valid,
    input wire interleaved_sampling_mode,
    output reg [NCH-1:0] ready_led,
    output reg [NCH-1:0] trig_led,
    output reg force_trig,
    output reg internal_trig,
    // acquisition memory
    output reg acq_start,
    output reg acq_abort,
    output reg [7:0] seg_index,
    output reg [31:0] seg_points,
    output reg [31:0] seg_span,
    input wire mem_done,
    output reg display_update,
    output reg [7:0] display_segs,
    // automatic configuration
    input wire [NCH-1:0] chan_in_use,
    input wire [NCH-1:0] sig_ok,
    input wire [NCH*32-1:0] meas_tpd,
    output reg meas_req,
    input wire meas_done,
    output reg [3:0] trig_src,
    output reg [31:0] time_per_div,
    output reg [NCH-1:0] vert_adjust
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_ARMED = 4'h2;
    localparam [3:0] ST_CAPT = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;
    localparam [1:0] AC_IDLE = 2'h1;
    localparam [1:0] AC_MEAS = 2'h2;

    reg [3:0] mode;
    reg [3:0] state;
    reg [1:0] ac_state;
    reg [31:0] config_reg;
    reg [7:0] part_cnt;
    reg [23:0] tmo_cnt;
    reg halted;
    reg no_signal;
    reg ac_apply;
    reg [31:0] ac_tpd;
    reg [3:0] next_mode;
    reg resel;
    reg found;
    reg [3:0] pick;
    reg [31:0] pick_tpd;
    integer i;

    wire [7:0] seg_count = config_reg[`CFG_SEGS_LSB +: 8];
    wire sequence_normal = config_reg[`CFG_SEQTYPE_BIT];
    wire [7:0] ilv_need = config_reg[`CFG_ILV_LSB +: 8];
    wire ac_go = key_autocfg && (ac_state == AC_IDLE);
    wire acquiring = (state == ST_ARMED) || (state == ST_CAPT);

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    wire wr = awvalid && wvalid && !bvalid;
    wire [7:0] waddr = {awaddr[7:2], 2'h0};
    wire [7:0] raddr = {araddr[7:2], 2'h0};
    wire wr_tpd = wr && (waddr == `REG_TPD);
    wire tpd_chg = wr_tpd || ac_apply;
    assign awready = wr;
    assign wready = wr;
    assign arready = !rvalid;

    always @(posedge clk) begin
        if (!rstn) begin
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            config_reg <= `CFG_RESET;
            time_per_div <= `TPD_RESET;
        end else begin
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (ac_apply) begin
                time_per_div <= ac_tpd;
            end
            if (wr) begin
                bvalid <= 1'b1;
                bresp <= `RESP_OKAY;
                if (waddr == `REG_CONFIG) begin
                    config_reg <= merge(config_reg, wdata, wstrb);
                end else if (waddr == `REG_TPD) begin
                    if (!ac_apply) begin
                        time_per_div <= merge(time_per_div, wdata, wstrb);
                    end
                end else begin
                    bresp <= `RESP_SLVERR;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else if (rvalid) begin
            if (rready) begin
                rvalid <= 1'b0;
            end
        end else if (arvalid) begin
            rvalid <= 1'b1;
            rresp <= `RESP_OKAY;
            case (raddr)
                `REG_CONFIG: rdata <= config_reg;
                `REG_TPD: rdata <= time_per_div;
                `REG_STATUS: rdata <= {14'h0000, halted, ac_state[1], seg_index, state, mode};
                `REG_AUTOCFG: rdata <= {23'h00_0000, no_signal, 4'h0, trig_src};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= `RESP_SLVERR;
                end
            endcase
        end
    end

    // ----------------------------------------
    // mode keys
    // ----------------------------------------
    // segmented mode only from the upper key; there the upper key reselects
    always @* begin
        next_mode = mode;
        resel = 1'b0;
        case (mode)
            `MODE_SINGLE: begin
                if (key_upper) begin
                    next_mode = `MODE_NORMAL;
                end else if (key_lower) begin
                    resel = 1'b1;
                end
            end
            `MODE_NORMAL: begin
                if (key_upper || key_lower) begin
                    next_mode = `MODE_AUTO;
                end
            end
            `MODE_AUTO: begin
                if (key_upper) begin
                    next_mode = `MODE_SEG;
                end else if (key_lower) begin
                    next_mode = `MODE_SINGLE;
                end
            end
            `MODE_SEG: begin
                if (key_lower) begin
                    next_mode = `MODE_SINGLE;
                end else if (key_upper) begin
                    resel = 1'b1;
                end
            end
            default: next_mode = `MODE_SINGLE;
        endcase
        if (ac_go) begin
            next_mode = `MODE_AUTO;
            resel = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            mode <= `MODE_SINGLE;
        end else begin
            mode <= next_mode;
        end
        single_mode_indicator <= rstn && (next_mode == `MODE_SINGLE);
        normal_mode_indicator <= rstn && (next_mode == `MODE_NORMAL);
        auto_mode_indicator <= rstn && (next_mode == `MODE_AUTO);
        segmented_mode_indicator <= rstn && (next_mode == `MODE_SEG);
    end

    // ----------------------------------------
    // auto timeout
    // ----------------------------------------
    wire [23:0] tmo_lim = interleaved_sampling_mode ? AUTO_TMO_ILV_CYC : AUTO_TMO_CYC;
    wire tmo_hit = (mode == `MODE_AUTO) && (tmo_cnt >= tmo_lim - 24'h00_0001);

    always @(posedge clk) begin
        // a re-arm that stays in armed must restart the count as well
        if (!rstn || state != ST_ARMED || |trig_valid || next_mode != mode || resel || tpd_chg) begin
            tmo_cnt <= 24'h00_0000;
        end else if (!tmo_hit) begin
            tmo_cnt <= tmo_cnt + 24'h00_0001;
        end
    end

    // ----------------------------------------
    // acquisition sequencer
    // ----------------------------------------
    wire part_last = !interleaved_sampling_mode || (part_cnt + 8'h01 >= ilv_need);
    wire seg_more = (mode == `MODE_SEG) && (seg_index + 8'h01 < seg_count);
    wire stop_after = (mode == `MODE_SINGLE) || ((mode == `MODE_SEG) && !sequence_normal);

    always @(posedge clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            part_cnt <= 8'h00;
            seg_index <= 8'h00;
            halted <= 1'b0;
            trig_led <= {NCH{1'b0}};
            force_trig <= 1'b0;
            internal_trig <= 1'b0;
            acq_start <= 1'b0;
            acq_abort <= 1'b0;
            display_update <= 1'b0;
            display_segs <= 8'h00;
        end else begin
            force_trig <= 1'b0;
            internal_trig <= 1'b0;
            acq_start <= 1'b0;
            acq_abort <= 1'b0;
            display_update <= 1'b0;
            if (next_mode != mode) begin
                // any new mode starts a fresh acquisition
                acq_abort <= acquiring;
                state <= ST_ARMED;
                part_cnt <= 8'h00;
                seg_index <= 8'h00;
                halted <= 1'b0;
                trig_led <= {NCH{1'b0}};
            end else if (resel) begin
                if (mode == `MODE_SINGLE && state == ST_ARMED && part_cnt == 8'h00) begin
                    force_trig <= 1'b1;
                    acq_start <= 1'b1;
                    state <= ST_CAPT;
                end else if (mode == `MODE_SEG && acquiring) begin
                    acq_abort <= (state == ST_CAPT);
                    display_update <= 1'b1;
                    display_segs <= seg_index;
                    halted <= 1'b1;
                    state <= ST_DONE;
                end else if (!acquiring) begin
                    state <= ST_ARMED;
                    part_cnt <= 8'h00;
                    seg_index <= 8'h00;
                    halted <= 1'b0;
                    trig_led <= {NCH{1'b0}};
                end
            end else if (tpd_chg && acquiring) begin
                // restart from scratch; a finished result is left alone
                acq_abort <= 1'b1;
                state <= ST_ARMED;
                part_cnt <= 8'h00;
                seg_index <= 8'h00;
            end else begin
                case (state)
                    ST_IDLE: state <= ST_IDLE;
                    ST_ARMED: begin
                        if (|trig_valid || tmo_hit) begin
                            internal_trig <= !(|trig_valid) && tmo_hit;
                            acq_start <= 1'b1;
                            state <= ST_CAPT;
                        end
                    end
                    ST_CAPT: begin
                        if (mem_done) begin
                            if (!part_last) begin
                                part_cnt <= part_cnt + 8'h01;
                                state <= ST_ARMED;
                            end else if (seg_more) begin
                                part_cnt <= 8'h00;
                                seg_index <= seg_index + 8'h01;
                                state <= ST_ARMED;
                            end else begin
                                part_cnt <= 8'h00;
                                seg_index <= 8'h00;
                                display_update <= 1'b1;
                                display_segs <= seg_index + 8'h01;
                                trig_led <= {NCH{1'b1}};
                                state <= stop_after ? ST_DONE : ST_ARMED;
                            end
                        end
                    end
                    ST_DONE: state <= ST_DONE;
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            ready_led <= {NCH{1'b0}};
        end else begin
            ready_led <= {NCH{acquiring}};
        end
    end

    // ----------------------------------------
    // segment geometry
    // ----------------------------------------
    // a divider is costly but the count changes rarely
    wire [34:0] span_w = {time_per_div, 3'h0} + {2'h0, time_per_div, 1'h0};
    wire [31:0] pts_w = (seg_count == 8'h00) ? MEM_DEPTH : MEM_DEPTH / {24'h00_0000, seg_count};

    always @(posedge clk) begin
        if (!rstn) begin
            seg_span <= 32'h0000_0000;
            seg_points <= 32'h0000_0000;
        end else begin
            seg_span <= span_w[31:0];
            seg_points <= pts_w;
        end
    end

    // ----------------------------------------
    // automatic configuration
    // ----------------------------------------
    always @* begin
        found = 1'b0;
        pick = 4'h0;
        pick_tpd = `TB_DEFAULT_NS;
        for (i = NCH - 1; i >= 0; i = i - 1) begin
            if (chan_in_use[i] && sig_ok[i]) begin
                found = 1'b1;
                pick = i[3:0];
                pick_tpd = meas_tpd[i*32 +: 32];
            end
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            ac_state <= AC_IDLE;
            meas_req <= 1'b0;
            ac_apply <= 1'b0;
            ac_tpd <= `TB_DEFAULT_NS;
            trig_src <= 4'h0;
            no_signal <= 1'b0;
            vert_adjust <= {NCH{1'b0}};
        end else begin
            ac_apply <= 1'b0;
            vert_adjust <= {NCH{1'b0}};
            case (ac_state)
                AC_IDLE: begin
                    if (key_autocfg) begin
                        meas_req <= 1'b1;
                        ac_state <= AC_MEAS;
                    end
                end
                AC_MEAS: begin
                    if (key_autocfg) begin
                        meas_req <= 1'b0;
                        ac_state <= AC_IDLE;
                    end else if (meas_done) begin
                        meas_req <= 1'b0;
                        ac_apply <= 1'b1;
                        ac_tpd <= found ? pick_tpd : `TB_DEFAULT_NS;
                        trig_src <= pick;
                        no_signal <= !found;
                        vert_adjust <= chan_in_use;
                        ac_state <= AC_IDLE;
                    end
                end
                default: ac_state <= AC_IDLE;
            endcase
        end
    end
endmodule

// *** acq_ctrl_props.sv ***
// assertion checker bound to the acquisition controller ports
module acq_ctrl_props #(
    parameter NCH = 4,
    parameter [23:0] AUTO_TMO_CYC = 24'h000014,
    parameter [23:0] AUTO_TMO_ILV_CYC = 24'h000028
) (
    // clock and reset
    input wire clk,
    input wire rstn,
    // stimulus side
    input wire key_upper,
    input wire key_lower,
    input wire key_autocfg,
    input wire [NCH-1:0] trig_valid,
    input wire interleaved_sampling_mode,
    input wire mem_done,
    input wire meas_done,
    input wire [NCH-1:0] chan_in_use,
    // controller outputs
    input wire single_mode_indicator,
    input wire normal_mode_indicator,
    input wire auto_mode_indicator,
    input wire segmented_mode_indicator,
    input wire [NCH-1:0] ready_led,
    input wire [NCH-1:0] trig_led,
    input wire force_trig,
    input wire internal_trig,
    input wire acq_start,
    input wire acq_abort,
    input wire display_update,
    input wire [31:0] seg_span,
    input wire [31:0] time_per_div,
    input wire meas_req,
    input wire [NCH-1:0] vert_adjust
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // cycles since anything last re-armed
    // ----------------------------------------
    reg [23:0] quiet;
    wire rearm = (|trig_valid) || acq_start || mem_done || meas_done;
    // an abort shows one cycle after the re-arm it belongs to
    always @(posedge clk) begin
        if (!rstn || rearm || key_upper || key_lower || (key_autocfg && !auto_mode_indicator))
            quiet <= 24'h000000;
        else if (acq_abort)
            quiet <= 24'h000001;
        else
            quiet <= quiet + 24'h000001;
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    AST_FORCE: assert property (force_trig |-> acq_start && single_mode_indicator)
        else $error("forced trigger without capture start");
    AST_TIMEOUT: assert property (internal_trig |-> acq_start && auto_mode_indicator
        && quiet >= (interleaved_sampling_mode ? AUTO_TMO_ILV_CYC : AUTO_TMO_CYC) - 24'h000001)
        else $error("internal trigger early or outside auto");
    AST_ONEHOT: assert property ($past(rstn) |-> $onehot({single_mode_indicator,
        normal_mode_indicator, auto_mode_indicator, segmented_mode_indicator}))
        else $error("mode indicators not one-hot");
    AST_LEDS: assert property (ready_led == {NCH{ready_led[0]}}
        && trig_led == {NCH{trig_led[0]}}) else $error("plug-in leds disagree");
    AST_TRIGLED: assert property ($rose(trig_led[0]) |-> display_update)
        else $error("triggered lit without complete waveform");
    AST_SPAN: assert property ($stable(time_per_div) [*3] ##0 $past(rstn, 3)
        |-> seg_span == time_per_div * 32'h0000000A) else $error("segment span wrong");
    AST_SINGLE_STOP: assert property (single_mode_indicator && display_update
        ##1 (!key_lower && !key_upper && !key_autocfg) [*3] |-> !ready_led[0] && !acq_start)
        else $error("single mode re-armed by itself");
    AST_ABORT: assert property ((normal_mode_indicator || auto_mode_indicator)
        && (key_upper || key_lower) && ready_led[0] |=> acq_abort)
        else $error("mode change did not drop capture");
    AST_AC_ABORT: assert property (meas_req && key_autocfg |=> !meas_req
        && vert_adjust == {NCH{1'b0}}) else $error("autoconfig not aborted");
    AST_VERT: assert property (meas_req && meas_done && !key_autocfg
        |=> vert_adjust == $past(chan_in_use)) else $error("vertical adjust set wrong");
endmodule
bind acq_ctrl acq_ctrl_props #(.NCH(NCH), .AUTO_TMO_CYC(AUTO_TMO_CYC),
    .AUTO_TMO_ILV_CYC(AUTO_TMO_ILV_CYC)) props (.clk, .rstn, .key_upper, .key_lower,
    .key_autocfg, .trig_valid, .interleaved_sampling_mode, .mem_done, .meas_done,
    .chan_in_use, .single_mode_indicator, .normal_mode_indicator, .auto_mode_indicator,
    .segmented_mode_indicator, .ready_led, .trig_led, .force_trig, .internal_trig,
    .acq_start, .acq_abort, .display_update, .seg_span, .time_per_div, .meas_req,
    .vert_adjust);

// *** acq_partner.sv ***
// far-side model: capture memory and signal measurement
module acq_partner (
    // clock and reset
    input wire clk,
    input wire rstn,
    // answer latency in cycles
    input wire [7:0] lat,
    // requests from the controller
    input wire acq_start,
    input wire acq_abort,
    input wire meas_req,
    // answers, one-cycle pulses
    output reg mem_done,
    output reg meas_done
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] mc;
    reg [7:0] rc;
    reg busy;
    always @(posedge clk) begin
        mem_done <= 1'b0;
        meas_done <= 1'b0;
        mc <= mc - 8'h01;
        rc <= meas_req ? rc + 8'h01 : 8'h00;
        // an aborted capture never reports completion
        if (!rstn || acq_abort)
            busy <= 1'b0;
        else if (acq_start) begin
            busy <= 1'b1;
            mc <= lat;
        end else if (busy && mc == 8'h00) begin
            busy <= 1'b0;
            mem_done <= 1'b1;
        end
        if (rstn && meas_req && rc == lat)
            meas_done <= 1'b1;
    end
endmodule

// *** acq_ctrl_tb.sv ***
// self-checking bench for the acquisition controller
module acq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg key_upper = 1'b0, key_lower = 1'b0, key_autocfg = 1'b0;
    reg interleaved_sampling_mode = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, lat = 8'h04;
    reg [31:0] wdata = 32'h00000000;
    reg [3:0] wstrb = 4'hF, trig_valid = 4'h0, chan_in_use = 4'h1, sig_ok = 4'h0;
    reg [127:0] meas_tpd = {32'h00000400, 32'h00000300, 32'h00000200, 32'h00000100};
    wire awready, wready, bvalid, arready, rvalid, force_trig, internal_trig, acq_start;
    wire single_mode_indicator, normal_mode_indicator, auto_mode_indicator;
    wire segmented_mode_indicator, acq_abort, mem_done, display_update, meas_req, meas_done;
    wire [1:0] bresp, rresp;
    wire [3:0] ready_led, trig_led, trig_src, vert_adjust;
    wire [7:0] seg_index, display_segs;
    wire [31:0] rdata, seg_span, time_per_div, seg_points;
    wire [31:0] ind = {20'h00000, segmented_mode_indicator, auto_mode_indicator,
        normal_mode_indicator, single_mode_indicator, ready_led, trig_led};
    integer errors = 0, total_checks = 0, na = 0, i = 0;
    integer ev [0:5];
    // short timeouts keep the auto-mode waits brief
    acq_ctrl #(.AUTO_TMO_CYC(24'h000014), .AUTO_TMO_ILV_CYC(24'h000028)) DUT (.clk, .rstn,
        .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .key_upper,
        .key_lower, .key_autocfg, .single_mode_indicator, .normal_mode_indicator,
        .auto_mode_indicator, .segmented_mode_indicator, .trig_valid,
        .interleaved_sampling_mode, .ready_led, .trig_led, .force_trig, .internal_trig,
        .acq_start, .acq_abort, .seg_index, .seg_points, .seg_span, .mem_done,
        .display_update, .display_segs, .chan_in_use, .sig_ok, .meas_tpd, .meas_req,
        .meas_done, .trig_src, .time_per_div, .vert_adjust);
    acq_partner model (.clk, .rstn, .lat, .acq_start, .acq_abort, .meas_req, .mem_done,
        .meas_done);
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (rstn) begin
            ev[0] <= ev[0] + acq_start;
            ev[1] <= ev[1] + display_update;
            ev[2] <= ev[2] + acq_abort;
            ev[3] <= ev[3] + force_trig;
            ev[4] <= ev[4] + internal_trig;
            ev[5] <= ev[5] + (vert_adjust != 4'h0);
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task final_report;
        if (errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk);
    endtask
    task tmo(input integer k);
        if (k >= 300) begin
            errors = errors + 1;
            final_report;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] r);
        integer k;
        k = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do @(posedge clk); while (!awready && k++ < 300);
        {awvalid, wvalid} <= 2'h0;
        do @(posedge clk); while (!bvalid && k++ < 300);
        bready <= 1'b0;
        tmo(k);
        chk("bresp", 32'(bresp), 32'(r));
    endtask
    task rd(input [7:0] a, input [31:0] d, input [1:0] r);
        integer k;
        k = 0;
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do @(posedge clk); while (!arready && k++ < 300);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid && k++ < 300);
        rready <= 1'b0;
        tmo(k);
        chk("rdata", rdata, d);
        chk("rresp", 32'(rresp), 32'(r));
    endtask
    task key(input [2:0] v);
        @(posedge clk);
        {key_autocfg, key_lower, key_upper} <= v;
        @(posedge clk);
        {key_autocfg, key_lower, key_upper} <= 3'h0;
        tick(2);
    endtask
    task wev(input integer j, input integer n);
        integer k;
        k = 0;
        while (ev[j] < n && k++ < 300) @(posedge clk);
        tmo(k);
    endtask
    task trg(input bit acq);
        @(posedge clk);
        trig_valid <= 4'h1;
        @(posedge clk);
        trig_valid <= 4'h0;
        if (acq) begin
            na = na + 1;
            wev(0, na);
            tick(lat + 6);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        for (i = 0; i < 6; i++) ev[i] = 0;
        tick(16);
        rstn <= 1'b1;
        tick(2);
        rd(8'h00, 32'h0010000A, 2'h0);
        rd(8'h04, 32'h000003E8, 2'h0);
        rd(8'h10, 32'h00000000, 2'h2);
        wr(8'h08, 32'h000000FF, 2'h2);
        wr(8'h00, 32'h00020003, 2'h0);
        rd(8'h08, 32'h00000011, 2'h0);
        key(3'h2);
        chk("ind", ind, 32'h000001F0);
        trg(1);
        wev(1, 1);
        chk("ind", ind, 32'h0000010F);
        wr(8'h04, 32'h000003E8, 2'h0);
        chk("upd", ev[1] + ev[2], 1);
        trg(0);
        tick(8);
        chk("acq", ev[0], 1);
        key(3'h2);
        key(3'h2);
        wev(3, 1);
        na = na + 1;
        wev(1, 2);
        chk("acq", ev[0], 2);
        interleaved_sampling_mode <= 1'b1;
        key(3'h2);
        trg(1);
        chk("ind", ind, 32'h000001F0);
        trg(1);
        chk("ind", ind, 32'h0000010F);
        interleaved_sampling_mode <= 1'b0;
        key(3'h1);
        chk("ind", ind, 32'h000002F0);
        trg(1);
        trg(1);
        chk("upd", ev[1], 5);
        chk("ind", ind, 32'h000002FF);
        wr(8'h04, 32'h00000064, 2'h0);
        tick(3);
        chk("abort", ev[2], 1);
        chk("span", seg_span, 32'h000003E8);
        key(3'h2);
        chk("ind", ind, 32'h000004F0);
        wev(4, 1);
        interleaved_sampling_mode <= 1'b1;
        wev(4, 3);
        interleaved_sampling_mode <= 1'b0;
        key(3'h1);
        na = ev[0];
        i = ev[1];
        trg(1);
        trg(1);
        chk("ind", ind, 32'h000008F0);
        trg(1);
        chk("segs", 32'(display_segs), 32'h3);
        chk("pts", seg_points, 32'h00005555);
        chk("ind", ind, 32'h0000080F);
        trg(0);
        tick(8);
        chk("upd", ev[1], i + 1);
        key(3'h1);
        trg(1);
        key(3'h1);
        chk("segs", 32'(display_segs), 32'h1);
        chk("upd", ev[1], i + 2);
        key(3'h1);
        chk("idx", 32'(seg_index), 32'h0);
        chk("ind", ind, 32'h000008F0);
        wr(8'h00, 32'h00020103, 2'h0);
        lat <= 8'h1E;
        repeat (6) trg(1);
        chk("upd", ev[1], i + 4);
        chk("ind", ind, 32'h000008FF);
        lat <= 8'h04;
        key(3'h4);
        chk("mode", ind & 32'h00000F00, 32'h00000400);
        wev(5, 1);
        tick(3);
        chk("tpd", time_per_div, 32'h00002710);
        rd(8'h0C, 32'h00000100, 2'h0);
        chan_in_use <= 4'hE;
        sig_ok <= 4'h6;
        key(3'h4);
        wev(5, 2);
        tick(3);
        chk("tpd", time_per_div, 32'h00000200);
        chk("src", 32'(trig_src), 32'h1);
        rd(8'h0C, 32'h00000001, 2'h0);
        lat <= 8'h28;
        key(3'h4);
        key(3'h4);
        tick(50);
        chk("vert", ev[5], 2);
        final_report;
    end
endmodule
